// ===== rtl/sot_pkg.sv
// Shared constants for the overhead termination block
package sot_pkg;

  // Frame geometry of one STS-1 / STM-0 frame, in bytes
  localparam int FRAME_ROWS = 9;
  localparam int FRAME_COLS = 90;
  localparam int TOH_COLS = 3;
  // Rows 0..2 hold section overhead, rows 3..8 line overhead
  localparam int SECTION_ROWS = 3;
  localparam int POINTER_ROW = 3;
  localparam int SDCC_ROW = 2;
  localparam int LDCC_FIRST_ROW = 5;
  localparam int LDCC_LAST_ROW = 7;
  // Row holding the section parity byte
  localparam int B1_ROW = 1;
  // Row holding the line parity byte
  localparam int B2_ROW = 4;

  // Counter widths
  localparam int ROW_W = 4;
  localparam int COL_W = 7;

  // Mode codes on the configuration input
  localparam logic [1:0] MODE_CODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_CODE_SECTION = 2'h1;
  localparam logic [1:0] MODE_CODE_LINE = 2'h2;

  // Regenerated overhead values
  localparam logic [7:0] A1_VALUE = 8'hf6;
  localparam logic [7:0] A2_VALUE = 8'h28;
  localparam logic [7:0] J0_VALUE = 8'h01;
  localparam logic [3:0] H1_NDF_NORMAL = 4'h6;
  localparam logic [7:0] H3_VALUE = 8'h00;
  localparam logic [7:0] IDLE_OH_VALUE = 8'h00;

  // Ready threshold: free FIFO words needed to accept a byte
  localparam int READY_FREE_MIN = 3;

  // Active termination mode, latched at frame start
  typedef enum logic [1:0] {
    SOT_TRANSPARENT,
    SOT_SECTION,
    SOT_LINE
  } sot_mode_e;

endpackage

// ===== rtl/sot_fifo.sv
// Small flip-flop FIFO with a registered head word
`timescale 1ns/10ps
module sot_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic [$clog2(DEPTH+1)-1:0] free_out,
  // Draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // Whole module state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic head_valid;
    logic [WIDTH-1:0] head;
  } sot_fifo_s;

  sot_fifo_s st; // Current state
  sot_fifo_s next_st; // Next state
  logic push; // Word written this cycle
  logic pop; // Word moved into head

  // Honest flags from the counter
  assign in_ready_out = (st.count < CW'(DEPTH));
  assign free_out = CW'(DEPTH) - st.count;
  assign out_valid_out = st.head_valid;
  assign out_data_out = st.head;

  // Next-state logic
  always_comb begin
    next_st = st;
    push = in_valid_in && in_ready_out;
    pop = (st.count != '0) && (!st.head_valid || out_ready_in);
    // Write side
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data_in;
      next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH-1)) ? '0 : st.wr_ptr + 1'b1;
    end
    // Head register reload or drain
    if (pop) begin
      next_st.head = st.mem[st.rd_ptr];
      next_st.head_valid = 1'b1;
      next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH-1)) ? '0 : st.rd_ptr + 1'b1;
    end else if (out_ready_in) begin
      next_st.head_valid = 1'b0;
    end
    // Occupancy
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

endmodule

// ===== rtl/sot_overhead_term.sv
// SONET/SDH transport overhead termination stage with output FIFO
`timescale 1ns/10ps
module sot_overhead_term #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // Static configuration
  input wire logic [1:0] MODE_IN,
  input wire logic MUX_VARIANT_IN,
  input wire logic SDCC_EN_IN,
  input wire logic LDCC_EN_IN,
  input wire logic [7:0] SDCC_BYTE_IN,
  input wire logic [7:0] LDCC_BYTE_IN,
  // Client byte stream
  input wire logic VALID_IN,
  input wire logic SOF_IN,
  input wire logic [7:0] DATA_IN,
  output logic READY_OUT,
  // Trunk byte stream
  output logic VALID_OUT,
  output logic SOF_OUT,
  output logic [7:0] DATA_OUT,
  input wire logic READY_IN
);

  localparam int FW = $clog2(FIFO_DEPTH+1);

  // Whole module state
  typedef struct packed {
    logic [sot_pkg::ROW_W-1:0] row; // Row of next byte
    logic [sot_pkg::COL_W-1:0] col; // Column of next byte
    sot_pkg::sot_mode_e mode_act; // Mode of current frame
    logic mux_act; // Variant of current frame
    logic sdcc_act; // Section DCC insert for frame
    logic ldcc_act; // Line DCC insert for frame
    logic rdy; // Registered ready to client
    logic stg_valid; // Stage holds a byte
    logic stg_sof; // Stage byte starts a frame
    logic [7:0] stg_data; // Stage byte
    logic [7:0] b1_acc; // Parity over frame in progress
    logic [7:0] b1_hold; // Parity of last whole frame
    logic [7:0] b2_acc; // Line parity in progress
    logic [7:0] b2_hold; // Line parity of last frame
  } sot_state_s;

  sot_state_s st; // Current state
  sot_state_s next_st; // Next state

  // FIFO handshake wires
  logic fifo_in_ready; // FIFO can take a word
  logic [FW-1:0] fifo_free; // Free words in FIFO
  logic fifo_out_valid; // Head word valid
  logic [8:0] fifo_out_data; // Head word

  // Per-byte decode
  logic take; // Byte accepted this cycle
  logic [sot_pkg::ROW_W-1:0] cur_row; // Row of accepted byte
  logic [sot_pkg::COL_W-1:0] cur_col; // Column of accepted byte
  sot_pkg::sot_mode_e use_mode; // Mode for accepted byte
  logic use_mux; // Variant for accepted byte
  logic use_sdcc; // Section DCC insert for byte
  logic use_ldcc; // Line DCC insert for byte
  logic in_toh; // Byte is transport overhead
  logic in_sec; // Byte is section overhead
  logic in_line; // Byte is line overhead
  logic regen; // Byte is replaced
  logic [7:0] regen_byte; // Replacement value
  logic [7:0] out_byte; // Byte leaving this stage
  sot_pkg::sot_mode_e cfg_mode; // Decoded configuration mode

  // Configuration code to mode
  always_comb begin
    case (MODE_IN)
      sot_pkg::MODE_CODE_SECTION: begin
        cfg_mode = sot_pkg::SOT_SECTION;
      end
      sot_pkg::MODE_CODE_LINE: begin
        cfg_mode = sot_pkg::SOT_LINE;
      end
      default: begin
        cfg_mode = sot_pkg::SOT_TRANSPARENT;
      end
    endcase
  end

  // Position and mode of the byte being accepted
  always_comb begin
    take = VALID_IN && st.rdy;
    if (SOF_IN) begin
      cur_row = '0;
      cur_col = '0;
      use_mode = cfg_mode;
      use_mux = MUX_VARIANT_IN;
      use_sdcc = SDCC_EN_IN;
      use_ldcc = LDCC_EN_IN;
    end else begin
      cur_row = st.row;
      cur_col = st.col;
      use_mode = st.mode_act;
      use_mux = st.mux_act;
      use_sdcc = st.sdcc_act;
      use_ldcc = st.ldcc_act;
    end
    in_toh = (cur_col < sot_pkg::COL_W'(sot_pkg::TOH_COLS));
    in_sec = in_toh && (cur_row < sot_pkg::ROW_W'(sot_pkg::SECTION_ROWS));
    in_line = in_toh && !in_sec;
  end

  // Replacement value for each overhead byte position
  always_comb begin
    regen_byte = sot_pkg::IDLE_OH_VALUE;
    case (cur_row)
      // Framing row: A1, A2, J0
      sot_pkg::ROW_W'(0): begin
        if (cur_col == sot_pkg::COL_W'(0)) begin
          regen_byte = sot_pkg::A1_VALUE;
        end else if (cur_col == sot_pkg::COL_W'(1)) begin
          regen_byte = sot_pkg::A2_VALUE;
        end else begin
          regen_byte = sot_pkg::J0_VALUE;
        end
      end
      // Section parity row
      sot_pkg::ROW_W'(sot_pkg::B1_ROW): begin
        if (cur_col == sot_pkg::COL_W'(0)) begin
          regen_byte = st.b1_hold;
        end
      end
      // Section DCC row
      sot_pkg::ROW_W'(sot_pkg::SDCC_ROW): begin
        if (use_sdcc) begin
          regen_byte = SDCC_BYTE_IN;
        end
      end
      // Pointer row keeps the incoming pointer value
      sot_pkg::ROW_W'(sot_pkg::POINTER_ROW): begin
        if (cur_col == sot_pkg::COL_W'(0)) begin
          regen_byte = {sot_pkg::H1_NDF_NORMAL, 2'h0, DATA_IN[1:0]};
        end else if (cur_col == sot_pkg::COL_W'(1)) begin
          regen_byte = DATA_IN;
        end else begin
          regen_byte = sot_pkg::H3_VALUE;
        end
      end
      // Line parity row
      sot_pkg::ROW_W'(sot_pkg::B2_ROW): begin
        if (cur_col == sot_pkg::COL_W'(0)) begin
          regen_byte = st.b2_hold;
        end
      end
      // Line DCC rows and the rest
      default: begin
        if (use_ldcc && cur_row >= sot_pkg::ROW_W'(sot_pkg::LDCC_FIRST_ROW)
            && cur_row <= sot_pkg::ROW_W'(sot_pkg::LDCC_LAST_ROW)) begin
          regen_byte = LDCC_BYTE_IN;
        end
      end
    endcase
  end

  // Which bytes are replaced in each mode
  always_comb begin
    regen = 1'b0;
    case (use_mode)
      sot_pkg::SOT_TRANSPARENT: begin
        if (use_mux) begin
          regen = in_toh && ((cur_row == '0 && cur_col < sot_pkg::COL_W'(2))
                  || (cur_row == sot_pkg::ROW_W'(sot_pkg::B1_ROW) && cur_col == '0)
                  || cur_row == sot_pkg::ROW_W'(sot_pkg::POINTER_ROW));
        end else begin
          regen = 1'b0;
        end
      end
      sot_pkg::SOT_SECTION: begin
        if (use_mux) begin
          regen = in_sec;
        end else begin
          regen = in_sec || in_line;
        end
      end
      sot_pkg::SOT_LINE: begin
        regen = in_sec || in_line;
      end
      default: begin
        regen = 1'b0;
      end
    endcase
    out_byte = regen ? regen_byte : DATA_IN;
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    // Stage empties into the FIFO
    if (st.stg_valid && fifo_in_ready) begin
      next_st.stg_valid = 1'b0;
    end
    if (take) begin
      // Load stage
      next_st.stg_valid = 1'b1;
      next_st.stg_sof = SOF_IN;
      next_st.stg_data = out_byte;
      next_st.mode_act = use_mode;
      next_st.mux_act = use_mux;
      next_st.sdcc_act = use_sdcc;
      next_st.ldcc_act = use_ldcc;
      // Advance frame position
      if (cur_col == sot_pkg::COL_W'(sot_pkg::FRAME_COLS-1)) begin
        next_st.col = '0;
        if (cur_row == sot_pkg::ROW_W'(sot_pkg::FRAME_ROWS-1)) begin
          next_st.row = '0;
        end else begin
          next_st.row = cur_row + 1'b1;
        end
      end else begin
        next_st.col = cur_col + 1'b1;
        next_st.row = cur_row;
      end
      // Parity over outgoing frame
      if (SOF_IN) begin
        next_st.b1_hold = st.b1_acc;
        next_st.b1_acc = out_byte;
        next_st.b2_hold = st.b2_acc;
        next_st.b2_acc = '0;
      end else begin
        next_st.b1_acc = st.b1_acc ^ out_byte;
        if (!in_sec) begin
          next_st.b2_acc = st.b2_acc ^ out_byte;
        end
      end
    end
    // Ready only with room for stage and two more
    next_st.rdy = (fifo_free >= FW'(sot_pkg::READY_FREE_MIN));
  end

  // State register
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      st <= '0;
    end else if (CE_IN) begin
      st <= next_st;
    end
  end

  // Output buffer toward the trunk
  sot_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .ce_in(CE_IN),
    .in_valid_in(st.stg_valid),
    .in_data_in({st.stg_sof, st.stg_data}),
    .in_ready_out(fifo_in_ready),
    .free_out(fifo_free),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(READY_IN)
  );

  // Registered outputs
  assign READY_OUT = st.rdy;
  assign VALID_OUT = fifo_out_valid;
  assign SOF_OUT = fifo_out_data[8];
  assign DATA_OUT = fifo_out_data[7:0];

endmodule

// ===== dv/sot_overhead_term_asserts.sv
// Port-level checks for the overhead termination stage
`timescale 1ns/10ps
module sot_overhead_term_asserts #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // Client side
  input wire logic [1:0] MODE_IN,
  input wire logic MUX_VARIANT_IN,
  input wire logic VALID_IN,
  input wire logic SOF_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic READY_OUT,
  // Trunk side
  input wire logic VALID_OUT,
  input wire logic SOF_OUT,
  input wire logic [7:0] DATA_OUT,
  input wire logic READY_IN
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  logic regen; // Framing regenerated in latched mode
  logic [7:0] sof_byte; // Last client frame byte taken
  // Latch handling when a frame byte is taken
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      regen <= 1'b0;
      sof_byte <= 8'h00;
    end else if (CE_IN && VALID_IN && READY_OUT && SOF_IN) begin
      regen <= MUX_VARIANT_IN || MODE_IN == 2'h1 || MODE_IN == 2'h2;
      sof_byte <= DATA_IN;
    end
  end
  property p_hold_data;
    VALID_OUT && !READY_IN && CE_IN |=> VALID_OUT && $stable(DATA_OUT);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("output word changed while stalled");
  property p_hold_sof;
    VALID_OUT && !READY_IN && CE_IN |=> $stable(SOF_OUT);
  endproperty
  a_hold_sof: assert property (p_hold_sof) else $error("frame mark changed while stalled");
  property p_reset_quiet;
    $fell(RESET_IN) |-> !VALID_OUT && !READY_OUT && !SOF_OUT;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_ready_wake;
    $fell(RESET_IN) && CE_IN |-> ##[1:3] READY_OUT;
  endproperty
  a_ready_wake: assert property (p_ready_wake) else $error("ready never rose after reset");
  property p_regen_a1;
    VALID_OUT && SOF_OUT && regen |-> DATA_OUT == sot_pkg::A1_VALUE;
  endproperty
  a_regen_a1: assert property (p_regen_a1) else $error("framing byte not regenerated");
  property p_transp_sof;
    VALID_OUT && SOF_OUT && !regen |-> DATA_OUT == sof_byte;
  endproperty
  a_transp_sof: assert property (p_transp_sof) else $error("frame byte altered");
  property p_refuse;
    (VALID_IN && !READY_IN && CE_IN)[*8] |-> !READY_OUT;
  endproperty
  a_refuse: assert property (p_refuse) else $error("input accepted into full buffer");
endmodule
bind sot_overhead_term sot_overhead_term_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) sot_overhead_term_asserts_inst (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .CE_IN(CE_IN), .MODE_IN(MODE_IN),
  .MUX_VARIANT_IN(MUX_VARIANT_IN), .VALID_IN(VALID_IN), .SOF_IN(SOF_IN), .DATA_IN(DATA_IN),
  .READY_OUT(READY_OUT), .VALID_OUT(VALID_OUT), .SOF_OUT(SOF_OUT), .DATA_OUT(DATA_OUT), .READY_IN(READY_IN)
);

// ===== dv/sot_sink_model.sv
// Trunk-side sink that stalls in short and long bursts
`timescale 1ns/10ps
module sot_sink_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Flow control toward the stage
  output logic ready_out
);
  logic [6:0] cnt = 7'h00; // Stall pattern counter
  // Advance off the sampling edge
  always @(negedge clk_in) begin
    if (rst_in) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end
  // Long stall of 16 cycles, plus brief gaps
  assign ready_out = !(cnt[6:4] == 3'h7) && !(cnt[3] && cnt[1:0] == 2'h3);
endmodule

// ===== dv/test_sot_overhead_term.sv
// Self-checking bench for the overhead termination stage
`timescale 1ns/10ps
module test_sot_overhead_term;
  // Stimulus and observed signals
  logic CLOCK_IN = 1'b0;
  logic RESET_IN = 1'b1;
  logic CE_IN = 1'b1;
  logic [1:0] MODE_IN = 2'h0;
  logic MUX_VARIANT_IN = 1'b0;
  logic SDCC_EN_IN = 1'b0;
  logic LDCC_EN_IN = 1'b0;
  logic [7:0] SDCC_BYTE_IN = 8'h00;
  logic [7:0] LDCC_BYTE_IN = 8'h00;
  logic VALID_IN = 1'b0;
  logic SOF_IN = 1'b0;
  logic [7:0] DATA_IN = 8'h00;
  logic READY_OUT, VALID_OUT, SOF_OUT, READY_IN;
  logic [7:0] DATA_OUT;
  // Scoreboard and reference frame state
  logic [8:0] exp_q[$];
  int errors = 0;
  int num_checks = 0;
  int row = 0;
  int col = 0;
  logic [31:0] seed = 32'h15;
  logic [1:0] lm = 2'h0;
  logic lv = 1'b0, lsd = 1'b0, lld = 1'b0;
  logic [7:0] b1 = 8'h00, b2 = 8'h00, acc_a = 8'h00, acc_l = 8'h00;
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected output byte at the current position
  function automatic logic [7:0] expb(input logic [7:0] d);
    logic oh;
    logic rg;
    oh = col < 3;
    if (!lv) begin
      rg = oh && (lm == 2'h1 || lm == 2'h2);
    end else if (lm == 2'h1) begin
      rg = oh && row < 3;
    end else if (lm == 2'h2) begin
      rg = oh;
    end else begin
      rg = (row == 0 && col < 2) || (row == 1 && col == 0) || (row == 3 && oh);
    end
    if (!rg) return d;
    case (row)
      0: return col == 0 ? sot_pkg::A1_VALUE : (col == 1 ? sot_pkg::A2_VALUE : sot_pkg::J0_VALUE);
      1: return col == 0 ? b1 : 8'h00;
      2: return lsd ? SDCC_BYTE_IN : 8'h00;
      3: return col == 0 ? {sot_pkg::H1_NDF_NORMAL, 2'b00, d[1:0]} : (col == 1 ? d : sot_pkg::H3_VALUE);
      4: return col == 0 ? b2 : 8'h00;
      5, 6, 7: return lld ? LDCC_BYTE_IN : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  // Offer one byte, note its expected output once taken
  task automatic send(input logic s, input logic [7:0] d);
    logic [7:0] e;
    @(negedge CLOCK_IN);
    VALID_IN = 1'b1;
    SOF_IN = s;
    DATA_IN = d;
    while (READY_OUT !== 1'b1) @(negedge CLOCK_IN);
    if (s) begin
      lm = MODE_IN;
      lv = MUX_VARIANT_IN;
      lsd = SDCC_EN_IN;
      lld = LDCC_EN_IN;
      b1 = acc_a;
      b2 = acc_l;
      acc_a = 8'h00;
      acc_l = 8'h00;
      row = 0;
      col = 0;
    end
    e = expb(d);
    acc_a = acc_a ^ e;
    if (row > 2 || col > 2) acc_l = acc_l ^ e;
    exp_q.push_back({s, e});
    col++;
    if (col == 90) begin
      col = 0;
      row = (row + 1) % 9;
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock
  initial begin
    forever #50 CLOCK_IN = ~CLOCK_IN;
  end
  sot_overhead_term #(.FIFO_DEPTH(4)) sot_overhead_term_inst (
    .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .CE_IN(CE_IN), .MODE_IN(MODE_IN),
    .MUX_VARIANT_IN(MUX_VARIANT_IN), .SDCC_EN_IN(SDCC_EN_IN), .LDCC_EN_IN(LDCC_EN_IN),
    .SDCC_BYTE_IN(SDCC_BYTE_IN), .LDCC_BYTE_IN(LDCC_BYTE_IN), .VALID_IN(VALID_IN), .SOF_IN(SOF_IN),
    .DATA_IN(DATA_IN), .READY_OUT(READY_OUT), .VALID_OUT(VALID_OUT), .SOF_OUT(SOF_OUT),
    .DATA_OUT(DATA_OUT), .READY_IN(READY_IN)
  );
  sot_sink_model sot_sink_model_inst (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .ready_out(READY_IN));
  // Compare each word the sink takes with the oldest note
  always @(posedge CLOCK_IN) begin
    if (VALID_OUT === 1'b1 && READY_IN === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0 || {SOF_OUT, DATA_OUT} !== exp_q[0]) begin
        errors++;
        $display("[FAIL] %0t unexpected output word %h", $time, DATA_OUT);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  // Every mode code on both variants, one frame each
  initial begin
    repeat (6) @(posedge CLOCK_IN);
    @(negedge CLOCK_IN);
    RESET_IN = 1'b0;
    for (int f = 0; f < 8; f++) begin
      MUX_VARIANT_IN = f[2];
      MODE_IN = f[1:0];
      SDCC_EN_IN = (f[1:0] == 2'h1 || f[1:0] == 2'h2);
      LDCC_EN_IN = (f[1:0] == 2'h2);
      SDCC_BYTE_IN = 8'(rnd());
      LDCC_BYTE_IN = 8'(rnd());
      for (int i = 0; i < 810; i++) begin
        if (i == 400) MODE_IN = 2'(rnd());
        send(i == 0, 8'(rnd()));
        if (rnd() % 8 == 0) begin
          @(negedge CLOCK_IN);
          VALID_IN = 1'b0;
        end
      end
    end
    @(negedge CLOCK_IN);
    VALID_IN = 1'b0;
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge CLOCK_IN);
    if (exp_q.size() != 0) begin
      errors++;
      $display("[FAIL] %0t words never delivered", $time);
    end
    close_out();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge CLOCK_IN);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule
